/* rtl/rot_bank_pkg.sv */
package rot_bank_pkg;

    // ------------------------------------------------------------
    // Flag register layout
    // ------------------------------------------------------------
    localparam int unsigned FLAG_C   = 7;
    localparam int unsigned FLAG_Z   = 6;
    localparam int unsigned FLAG_S   = 5;
    localparam int unsigned FLAG_V   = 4;
    localparam int unsigned FLAG_D   = 3;
    localparam int unsigned FLAG_H   = 2;
    localparam int unsigned FLAG_BA  = 0;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_LEFT_CARRY_REG   = 8'h10;
    localparam logic [7:0] OPC_LEFT_CARRY_IND   = 8'h11;
    localparam logic [7:0] OPC_RIGHT_CARRY_REG  = 8'hC0;
    localparam logic [7:0] OPC_RIGHT_CARRY_IND  = 8'hC1;
    localparam logic [7:0] OPC_RIGHT_PLAIN_REG  = 8'hE0;
    localparam logic [7:0] OPC_RIGHT_PLAIN_IND  = 8'hE1;
    localparam logic [7:0] OPC_BANK0   = 8'h4F;
    localparam logic [7:0] OPC_BANK1   = 8'h5F;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned INSTR_CYCLES = 4;
    localparam logic [2:0]  CNT_FIRST    = 3'h1;
    localparam logic [2:0]  CNT_LAST     = 3'(INSTR_CYCLES - 1);

    typedef enum logic [1:0] {
        K_LEFT_CARRY,
        K_RIGHT_PLAIN,
        K_RIGHT_CARRY
    } rot_kind_e;

    typedef enum logic [2:0] {
        OP_LEFT_CARRY,
        OP_RIGHT_PLAIN,
        OP_RIGHT_CARRY,
        OP_BANK0,
        OP_BANK1,
        OP_BAD
    } op_e;

    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } state_e;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       zero;
        logic       sign;
        logic       ovf;
    } rot_out_s;

    typedef struct packed {
        state_e     state;
        logic [2:0] cnt;
        op_e        op;
        logic       indirect;
        logic [7:0] operand;
        logic [7:0] flags;
        logic [7:0] result;
        logic       result_we;
        logic       done;
        logic       illegal;
        logic       ind_out;
    } core_s;

endpackage

/* rtl/rotate_core.sv */
`timescale 1ns/1ns
module rotate_core (
    input  wire rot_bank_pkg::rot_kind_e kind_i,
    input  wire logic [7:0]              operand_i,
    input  wire logic                    carry_i,
    output rot_bank_pkg::rot_out_s       out_o
);

    logic [7:0] res;

    always_comb begin
        res = operand_i;
        case (kind_i)
            rot_bank_pkg::K_LEFT_CARRY: begin
                res = {operand_i[6:0], carry_i};
            end
            rot_bank_pkg::K_RIGHT_PLAIN: begin
                res = {operand_i[0], operand_i[7:1]};
            end
            default: begin
                res = {carry_i, operand_i[7:1]};
            end
        endcase
        out_o.result = res;
        // Left rotate spills bit 7; both right rotates spill bit 0
        out_o.carry  = (kind_i == rot_bank_pkg::K_LEFT_CARRY) ? operand_i[7]
                                                              : operand_i[0];
        out_o.zero   = (res == rot_bank_pkg::BYTE_ZERO);
        out_o.sign   = res[7];
        out_o.ovf    = res[7] ^ operand_i[7];
    end

endmodule

/* rtl/rotate_bank_unit.sv */
`timescale 1ns/1ns
// Operation
// - Rotate left through carry shifts the operand up, fills bit 0 from old carry, carry takes old bit 7.
// - Rotate left through carry copies operand bit n into result bit n+1 for n from 0 to 6.
// - After rotate left through carry, carry is set exactly when the old bit 7 was one.
// - Plain rotate right moves old bit 0 into result bit 7 and into carry.
// - Plain rotate right copies bit n+1 into bit n for n from 0 to 6 without the old carry.
// - Rotate right through carry shifts down and fills bit 7 from the carry held before.
// - Rotate right through carry loads carry from old operand bit 0.
// - The two rotates through carry move operand and carry together by exactly one position per execution.
// - Every rotate sets zero when the 8-bit result is zero and clears it otherwise.
// - Every rotate copies result bit 7 into the sign flag.
// - Every rotate sets overflow when the operand sign bit changed, and clears it otherwise.
// - Select bank zero clears flag bit 0.
// - Select bank one sets flag bit 0.
// - Bank selects leave every other flag unchanged.
module rotate_bank_unit (
    input  wire  logic       mclk_i,
    input  wire  logic       resetn_i,
    input  wire  logic       issue_i,
    input  wire  logic [7:0] opcode_i,
    input  wire  logic [7:0] operand_i,
    input  wire  logic       flags_we_i,
    input  wire  logic [7:0] flags_wdata_i,
    output logic       busy_o,
    output logic       done_o,
    output logic       illegal_o,
    output logic [7:0] result_o,
    output logic       result_we_o,
    output logic       indirect_register_mode_o,
    output logic [7:0] flags_o,
    output logic       bank_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rot_bank_pkg::core_s      st_r;
    rot_bank_pkg::core_s      st_nxt;
    rot_bank_pkg::op_e        dec_op;
    logic                     dec_ind;
    rot_bank_pkg::rot_kind_e  kind;
    rot_bank_pkg::rot_out_s   rot;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        dec_op  = rot_bank_pkg::OP_BAD;
        dec_ind = opcode_i[0];
        if (opcode_i == rot_bank_pkg::OPC_LEFT_CARRY_REG
            || opcode_i == rot_bank_pkg::OPC_LEFT_CARRY_IND) begin
            dec_op = rot_bank_pkg::OP_LEFT_CARRY;
        end else if (opcode_i == rot_bank_pkg::OPC_RIGHT_PLAIN_REG
                     || opcode_i == rot_bank_pkg::OPC_RIGHT_PLAIN_IND) begin
            dec_op = rot_bank_pkg::OP_RIGHT_PLAIN;
        end else if (opcode_i == rot_bank_pkg::OPC_RIGHT_CARRY_REG
                     || opcode_i == rot_bank_pkg::OPC_RIGHT_CARRY_IND) begin
            dec_op = rot_bank_pkg::OP_RIGHT_CARRY;
        end else if (opcode_i == rot_bank_pkg::OPC_BANK0) begin
            dec_op = rot_bank_pkg::OP_BANK0;
        end else if (opcode_i == rot_bank_pkg::OPC_BANK1) begin
            dec_op = rot_bank_pkg::OP_BANK1;
        end
    end

    always_comb begin
        case (st_r.op)
            rot_bank_pkg::OP_LEFT_CARRY:  kind = rot_bank_pkg::K_LEFT_CARRY;
            rot_bank_pkg::OP_RIGHT_PLAIN: kind = rot_bank_pkg::K_RIGHT_PLAIN;
            default:                      kind = rot_bank_pkg::K_RIGHT_CARRY;
        endcase
    end

    rotate_core u_rot (
        .kind_i    (kind),
        .operand_i (st_r.operand),
        .carry_i   (st_r.flags[rot_bank_pkg::FLAG_C]),
        .out_o     (rot)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.done      = 1'b0;
        st_nxt.result_we = 1'b0;
        st_nxt.illegal   = 1'b0;
        case (st_r.state)
            rot_bank_pkg::ST_IDLE: begin
                if (issue_i) begin
                    st_nxt.state    = rot_bank_pkg::ST_EXEC;
                    st_nxt.cnt      = rot_bank_pkg::CNT_FIRST;
                    st_nxt.op       = dec_op;
                    st_nxt.indirect = dec_ind;
                    st_nxt.operand  = operand_i;
                end else if (flags_we_i) begin
                    st_nxt.flags = flags_wdata_i;
                end
            end
            default: begin
                st_nxt.cnt = st_r.cnt + 3'h1;
                // Results commit on the last of the four cycles
                if (st_r.cnt == rot_bank_pkg::CNT_LAST) begin
                    st_nxt.state = rot_bank_pkg::ST_IDLE;
                    st_nxt.done  = 1'b1;
                    case (st_r.op)
                        rot_bank_pkg::OP_LEFT_CARRY,
                        rot_bank_pkg::OP_RIGHT_PLAIN,
                        rot_bank_pkg::OP_RIGHT_CARRY: begin
                            st_nxt.result    = rot.result;
                            st_nxt.result_we = 1'b1;
                            st_nxt.ind_out   = st_r.indirect;
                            // D and H are carried over untouched
                            st_nxt.flags[rot_bank_pkg::FLAG_C] = rot.carry;
                            st_nxt.flags[rot_bank_pkg::FLAG_Z] = rot.zero;
                            st_nxt.flags[rot_bank_pkg::FLAG_S] = rot.sign;
                            st_nxt.flags[rot_bank_pkg::FLAG_V] = rot.ovf;
                        end
                        rot_bank_pkg::OP_BANK0: begin
                            st_nxt.flags[rot_bank_pkg::FLAG_BA] = 1'b0;
                        end
                        rot_bank_pkg::OP_BANK1: begin
                            st_nxt.flags[rot_bank_pkg::FLAG_BA] = 1'b1;
                        end
                        default: begin
                            st_nxt.illegal = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            st_r           <= '0;
            st_r.state     <= rot_bank_pkg::ST_IDLE;
            st_r.op        <= rot_bank_pkg::OP_BAD;
            st_r.flags     <= rot_bank_pkg::FLAGS_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o                   = (st_r.state == rot_bank_pkg::ST_EXEC);
    assign done_o                   = st_r.done;
    assign illegal_o                = st_r.illegal;
    assign result_o                 = st_r.result;
    assign result_we_o              = st_r.result_we;
    assign indirect_register_mode_o = st_r.ind_out;
    assign flags_o                  = st_r.flags;
    assign bank_o                   = st_r.flags[rot_bank_pkg::FLAG_BA];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence take_s(logic [7:0] a, logic [7:0] b);
        issue_i && !busy_o && (opcode_i == a || opcode_i == b);
    endsequence

    // Issue edge, three busy edges, then the edge that shows done
    instr_length_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        issue_i && !busy_o |-> ##1 (busy_o && !done_o) [*3] ##1 (done_o && !busy_o))
        else $error("Instruction did not complete in four cycles");

    left_carry_result_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        take_s(rot_bank_pkg::OPC_LEFT_CARRY_REG, rot_bank_pkg::OPC_LEFT_CARRY_IND) |-> ##4
        result_o == {$past(operand_i[6:0], 4), $past(flags_o[rot_bank_pkg::FLAG_C], 4)})
        else $error("Left rotate through carry result wrong");

    left_carry_flag_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        take_s(rot_bank_pkg::OPC_LEFT_CARRY_REG, rot_bank_pkg::OPC_LEFT_CARRY_IND) |-> ##4
        flags_o[rot_bank_pkg::FLAG_C] == $past(operand_i[7], 4))
        else $error("Left rotate carry not from bit 7");

    right_plain_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        take_s(rot_bank_pkg::OPC_RIGHT_PLAIN_REG, rot_bank_pkg::OPC_RIGHT_PLAIN_IND) |-> ##4
        result_o == {$past(operand_i[0], 4), $past(operand_i[7:1], 4)}
        && flags_o[rot_bank_pkg::FLAG_C] == $past(operand_i[0], 4))
        else $error("Plain right rotate wrong");

    right_carry_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        take_s(rot_bank_pkg::OPC_RIGHT_CARRY_REG, rot_bank_pkg::OPC_RIGHT_CARRY_IND) |-> ##4
        result_o == {$past(flags_o[rot_bank_pkg::FLAG_C], 4), $past(operand_i[7:1], 4)}
        && flags_o[rot_bank_pkg::FLAG_C] == $past(operand_i[0], 4))
        else $error("Right rotate through carry wrong");

    rot_flags_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        result_we_o |-> flags_o[rot_bank_pkg::FLAG_Z] == (result_o == rot_bank_pkg::BYTE_ZERO)
        && flags_o[rot_bank_pkg::FLAG_S] == result_o[7])
        else $error("Zero or sign flag wrong");

    rot_ovf_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        result_we_o |-> flags_o[rot_bank_pkg::FLAG_V] == (result_o[7] ^ st_r.operand[7]))
        else $error("Overflow flag wrong");

    rot_dh_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        result_we_o |-> flags_o[rot_bank_pkg::FLAG_D:rot_bank_pkg::FLAG_H]
        == $past(flags_o[rot_bank_pkg::FLAG_D:rot_bank_pkg::FLAG_H]))
        else $error("Rotate disturbed D or H");

    bank_zero_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        issue_i && !busy_o && opcode_i == rot_bank_pkg::OPC_BANK0 |-> ##4
        !bank_o && flags_o[7:1] == $past(flags_o[7:1], 4))
        else $error("Bank zero select wrong");

    bank_one_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        issue_i && !busy_o && opcode_i == rot_bank_pkg::OPC_BANK1 |-> ##4
        bank_o && flags_o[7:1] == $past(flags_o[7:1], 4))
        else $error("Bank one select wrong");

    illegal_done_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        illegal_o |-> done_o && !result_we_o && $stable(flags_o))
        else $error("Unknown opcode changed state");

    // A refused flag write or issue during execution must leave no trace
    busy_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        busy_o |-> $stable(flags_o) && $stable(result_o))
        else $error("Flags or result moved while busy");

    result_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !result_we_o |-> $stable(result_o) && $stable(indirect_register_mode_o))
        else $error("Result changed without a rotate");

    ind_mode_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        result_we_o |-> indirect_register_mode_o == $past(opcode_i[0], 4))
        else $error("Register mode report wrong");

endmodule

/* tb/rot_seq_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Instruction sequencer seen from the rotate and bank unit
// ------------------------------------------------------------
module rot_seq_model (
    input  wire  logic       mclk_i,
    output logic             issue_o,
    output logic [7:0]       opcode_o,
    output logic [7:0]       operand_o,
    output logic             flags_we_o,
    output logic [7:0]       flags_wdata_o
);
    initial begin
        issue_o       = 1'b0;
        opcode_o      = 8'h00;
        operand_o     = 8'h00;
        flags_we_o    = 1'b0;
        flags_wdata_o = 8'h00;
    end

    // Called at a rising edge; returns at the edge that shows done, so the
    // next call issues back to back. The poke is refused while busy.
    task automatic op(input logic [7:0] oc, input logic [7:0] od, input bit poke);
        issue_o   <= 1'b1;
        opcode_o  <= oc;
        operand_o <= od;
        @(posedge mclk_i);
        // Operand is no longer held after the take, so it shows a changed value
        issue_o       <= poke;
        opcode_o      <= poke ? 8'h5F : ~oc;
        operand_o     <= ~od;
        flags_we_o    <= poke;
        flags_wdata_o <= 8'hFF;
        @(posedge mclk_i);
        issue_o    <= 1'b0;
        flags_we_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
    endtask

    task automatic wflag(input logic [7:0] v);
        flags_we_o    <= 1'b1;
        flags_wdata_o <= v;
        @(posedge mclk_i);
        flags_we_o    <= 1'b0;
        flags_wdata_o <= ~v;
    endtask
endmodule

/* tb/rotate_and_bank_select_unit_test.sv */
`timescale 1ns/1ns
`define CHK(n, a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, b, a); end end
module rotate_and_bank_select_unit_test;
    localparam int FC = rot_bank_pkg::FLAG_C;
    localparam int FZ = rot_bank_pkg::FLAG_Z;
    localparam int FS = rot_bank_pkg::FLAG_S;
    localparam int FV = rot_bank_pkg::FLAG_V;
    logic        mclk_i;
    logic        resetn_i;
    logic        issue, flags_we, busy, done, illegal, result_we, ind, bank;
    logic [7:0]  opcode, operand, flags_wdata, result, flags;
    logic [7:0]  mf, mres;
    logic        mind;
    logic [18:0] q[$];
    logic [18:0] e;
    logic [7:0]  tbl[9] = '{8'h10, 8'h11, 8'hC0, 8'hC1, 8'hE0, 8'hE1, 8'h4F, 8'h5F, 8'h77};
    int          error_cnt, checks, cyc, t0;

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    rot_seq_model rot_seq_model_i (.mclk_i(mclk_i), .issue_o(issue), .opcode_o(opcode),
        .operand_o(operand), .flags_we_o(flags_we), .flags_wdata_o(flags_wdata));

    rotate_bank_unit rotate_bank_unit_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .issue_i(issue), .opcode_i(opcode), .operand_i(operand), .flags_we_i(flags_we),
        .flags_wdata_i(flags_wdata), .busy_o(busy), .done_o(done), .illegal_o(illegal),
        .result_o(result), .result_we_o(result_we), .indirect_register_mode_o(ind),
        .flags_o(flags), .bank_o(bank));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    task automatic expect_op(input logic [7:0] oc, input logic [7:0] od);
        logic [7:0] r;
        logic       nc, rot, bad;
        r   = od;
        nc  = mf[FC];
        rot = 1'b1;
        bad = 1'b0;
        case (oc)
            8'h10, 8'h11: begin r = {od[6:0], mf[FC]}; nc = od[7]; end
            8'hE0, 8'hE1: begin r = {od[0], od[7:1]}; nc = od[0]; end
            8'hC0, 8'hC1: begin r = {mf[FC], od[7:1]}; nc = od[0]; end
            8'h4F, 8'h5F: begin mf[0] = oc[4]; rot = 1'b0; end
            default: begin rot = 1'b0; bad = 1'b1; end
        endcase
        if (rot) begin
            mf[FC] = nc;
            mf[FZ] = (r == 8'h00);
            mf[FS] = r[7];
            mf[FV] = r[7] ^ od[7];
            mres   = r;
            mind   = oc[0];
        end
        q.push_back({bad, rot, mind, mres, mf});
    endtask

    task automatic run(input logic [7:0] oc, input logic [7:0] od, input bit poke);
        expect_op(oc, od);
        rot_seq_model_i.op(oc, od, poke);
    endtask

    task automatic wr(input logic [7:0] v);
        mf = v;
        rot_seq_model_i.wflag(v);
    endtask

    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(negedge mclk_i) begin
        cyc++;
        if (cyc - t0 >= 1 && cyc - t0 <= 3) `CHK("busy", busy, 1'b1)
        if (done) begin
            e = (q.size() > 0) ? q.pop_front() : 'x;
            `CHK("latency", cyc - t0, 4)
            `CHK("idle at done", busy, 1'b0)
            `CHK("illegal", illegal, e[18])
            `CHK("result_we", result_we, e[17])
            `CHK("indirect", ind, e[16])
            `CHK("result", result, e[15:8])
            `CHK("flags", flags, e[7:0])
            `CHK("bank", bank, e[0])
        end
        if (issue && !busy && resetn_i) t0 = cyc;
    end

    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn_i = 1'b0;
        {error_cnt, checks, cyc} = '0;
        t0   = -100;
        mf   = 8'h00;
        mres = 8'h00;
        mind = 1'b0;
        void'($urandom(32'h69DA));
        repeat (6) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(negedge mclk_i);
        `CHK("reset flags", flags, 8'h00)
        `CHK("reset result", result, 8'h00)
        `CHK("reset busy", busy, 1'b0)
        @(posedge mclk_i);
        wr(8'h00);
        run(8'h10, 8'hAA, 1'b0);
        run(8'h10, 8'h00, 1'b0);
        run(8'hE0, 8'h31, 1'b0);
        wr(8'h8C);
        run(8'hC1, 8'h55, 1'b0);
        // Refused poke while busy must not reach the bank bit or the flags
        run(8'h4F, 8'h00, 1'b1);
        for (int i = 0; i < 9; i++) run(tbl[i], 8'(i * 37), 1'b0);
        for (int i = 0; i < 80; i++) begin
            if ($urandom % 3 == 0) wr(8'($urandom));
            run(tbl[$urandom % 9], 8'($urandom), ($urandom % 5) == 0);
        end
        repeat (4) @(posedge mclk_i);
        `CHK("pending", q.size(), 0)
        results();
    end
endmodule
